// [include/aad_defs.svh]
// constants for the accumulator add/and datapath: offsets, fields, reset values
// Functional notes
// - add-to-memory: memory byte gets acc plus byte; all five arithmetic flags update
// - and-with-memory: acc gets acc AND memory byte; only zero flag changes
// - and-with-immediate: acc gets acc AND immediate; only zero flag changes
// - and-to-memory: memory byte gets memory byte AND acc
`ifndef AAD_DEFS_SVH
`define AAD_DEFS_SVH

// apb byte offsets
`define AAD_OFS_CMD        12'h000
`define AAD_OFS_ACC        12'h004
`define AAD_OFS_FLAGS      12'h008
`define AAD_OFS_MEM_ADDR   12'h00C
`define AAD_OFS_MEM_DATA   12'h010
`define AAD_OFS_STATUS     12'h014

// command register fields
`define AAD_CMD_OP_LSB     0
`define AAD_CMD_OP_MSB     1
`define AAD_CMD_ADDR_LSB   8
`define AAD_CMD_ADDR_MSB   15
`define AAD_CMD_IMM_LSB    16
`define AAD_CMD_IMM_MSB    23

// status register fields
`define AAD_STS_BUSY_BIT   0
`define AAD_STS_DONE_BIT   1
`define AAD_STS_CNT_LSB    16
`define AAD_STS_CNT_MSB    31

// widths and depths
`define AAD_DATA_W         8
`define AAD_ADDR_W         8
`define AAD_MEM_DEPTH      256
`define AAD_FLAG_W         5
`define AAD_CNT_W          16
`define AAD_PADDR_W        12

// flag masks, bit order carry, aux, zero, overflow, signed carry
`define AAD_MASK_ALL       5'h1F
`define AAD_MASK_ZERO      5'h04

// reset values
`define AAD_RST_ACC        8'h00
`define AAD_RST_FLAGS      5'h00
`define AAD_RST_CMD        32'h0000_0000
`define AAD_RST_MEM_ADDR   8'h00
`define AAD_RST_CNT        16'h0000

`endif

// [include/aad_pkg.sv]
// types of the accumulator add/and datapath
package aad_pkg;

    typedef enum logic [1:0] {
        OP_ADD_ACC_INTO_MEMORY,
        OP_AND_MEMORY_INTO_ACC,
        OP_AND_IMM_INTO_ACC,
        OP_AND_ACC_INTO_MEMORY
    } aad_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_EXEC
    } aad_state_t;

    typedef struct packed {
        logic signed_carry_flag;
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } aad_flags_t;

    typedef struct packed {
        logic [7:0] result;
        aad_flags_t flags;
        logic [4:0] flag_mask;
        logic       wr_acc;
        logic       wr_mem;
    } aad_alu_out_t;

endpackage

// [logic/aad_alu.sv]
// combinational add/and unit with flag generation
`timescale 1ns/1ps
`include "aad_defs.svh"

module aad_alu (
    // operation and operands
    input  wire aad_pkg::aad_op_t     op,
    input  wire logic [7:0]           acc,
    input  wire logic [7:0]           opnd,
    input  wire logic [7:0]           imm,
    // result bundle
    output aad_pkg::aad_alu_out_t     alu_out
);

    logic [8:0] sum9;
    logic [4:0] low5;
    logic [7:0] and_mem;
    logic [7:0] and_imm;
    logic       carry_in7;
    logic       ovf;
    logic       is_add;
    logic       is_imm;
    logic [7:0] res;

    assign sum9      = {1'b0, acc} + {1'b0, opnd};
    assign low5      = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    assign carry_in7 = acc[7] ^ opnd[7] ^ sum9[7];
    // overflow is carry into the sign bit differing from carry out of it
    assign ovf       = carry_in7 ^ sum9[8];
    assign and_mem   = acc & opnd;
    assign and_imm   = acc & imm;
    assign is_add    = (op == aad_pkg::OP_ADD_ACC_INTO_MEMORY);
    assign is_imm    = (op == aad_pkg::OP_AND_IMM_INTO_ACC);
    assign res       = is_add ? sum9[7:0] : (is_imm ? and_imm : and_mem);

    assign alu_out.result                  = res;
    assign alu_out.flags.carry_flag        = sum9[8];
    assign alu_out.flags.aux_carry_flag    = low5[4];
    assign alu_out.flags.zero_flag         = (res == 8'h00);
    assign alu_out.flags.overflow_flag     = ovf;
    assign alu_out.flags.signed_carry_flag = ovf ^ sum9[7];
    // logical ops touch only zero, the add touches all five
    assign alu_out.flag_mask = is_add ? `AAD_MASK_ALL : `AAD_MASK_ZERO;
    assign alu_out.wr_acc    = (op == aad_pkg::OP_AND_MEMORY_INTO_ACC) || is_imm;
    assign alu_out.wr_mem    = is_add || (op == aad_pkg::OP_AND_ACC_INTO_MEMORY);

endmodule // aad_alu

// [logic/aad_datapath.sv]
// apb-controlled accumulator add/and datapath with its own data memory
`timescale 1ns/1ps
`include "aad_defs.svh"

module aad_datapath (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // core state
    output logic [7:0]       ACC_VALUE,
    output logic [4:0]       FLAGS,
    output logic             BUSY
);

    // byte-lane merge used by every writable register except status
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // register state
    logic [7:0]               acc_q;
    logic [7:0]               acc_d;
    logic [4:0]               flags_q;
    logic [4:0]               flags_d;
    logic [31:0]              cmd_q;
    logic [31:0]              cmd_d;
    logic [7:0]               mem_addr_q;
    logic [7:0]               mem_addr_d;
    logic                     done_q;
    logic                     done_d;
    logic [15:0]              cnt_q;
    logic [15:0]              cnt_d;
    logic [7:0]               opnd_q;
    logic [7:0]               opnd_d;
    aad_pkg::aad_state_t      state_q;
    aad_pkg::aad_state_t      state_d;
    logic [7:0]               mem_q [`AAD_MEM_DEPTH];

    // apb output flops and the busy output flop
    logic [31:0]              prdata_q;
    logic [31:0]              prdata_d;
    logic                     pready_q;
    logic                     pready_d;
    logic                     pslverr_q;
    logic                     pslverr_d;
    logic                     busy_q;
    logic                     busy_d;

    // apb phase and decode
    logic                     access_ph;
    logic                     commit;
    logic                     commit_wr;
    logic                     sel_cmd;
    logic                     sel_acc;
    logic                     sel_flags;
    logic                     sel_maddr;
    logic                     sel_mdata;
    logic                     sel_status;
    logic                     mapped;
    logic                     busy_now;
    logic                     refuse;
    logic [31:0]              rd_mux;
    logic [31:0]              status_word;

    // execution
    logic                     start;
    logic                     exec_now;
    logic [7:0]               cmd_addr;
    logic [7:0]               cmd_imm;
    aad_pkg::aad_op_t         cmd_op;
    aad_pkg::aad_alu_out_t    alu_out;
    logic [4:0]               alu_flag_bits;
    logic                     exec_mem_we;
    logic                     apb_mem_we;
    logic [31:0]              mdata_merged;
    logic [31:0]              acc_merged;
    logic [31:0]              flags_merged;
    logic [31:0]              maddr_merged;
    logic                     done_clr;

    // one wait state: pready rises the cycle after the access phase starts
    assign access_ph  = PSEL && PENABLE;
    assign pready_d   = access_ph && !pready_q;
    assign commit     = access_ph && pready_q;
    assign commit_wr  = commit && PWRITE && !pslverr_q;

    assign sel_cmd    = (PADDR == `AAD_OFS_CMD);
    assign sel_acc    = (PADDR == `AAD_OFS_ACC);
    assign sel_flags  = (PADDR == `AAD_OFS_FLAGS);
    assign sel_maddr  = (PADDR == `AAD_OFS_MEM_ADDR);
    assign sel_mdata  = (PADDR == `AAD_OFS_MEM_DATA);
    assign sel_status = (PADDR == `AAD_OFS_STATUS);
    assign mapped     = sel_cmd || sel_acc || sel_flags || sel_maddr || sel_mdata
                        || sel_status;

    // writes that would race the running instruction are refused, status excepted
    assign busy_now   = (state_q != aad_pkg::ST_IDLE);
    assign refuse     = !mapped || (PWRITE && busy_now && !sel_status);
    assign pslverr_d  = pready_d && refuse;

    assign status_word = {cnt_q, 14'h0000, done_q, busy_now};

    always_comb begin
        if (!mapped) begin
            rd_mux = 32'h0000_0000;
        end else if (sel_cmd) begin
            rd_mux = cmd_q;
        end else if (sel_acc) begin
            rd_mux = {24'h00_0000, acc_q};
        end else if (sel_flags) begin
            rd_mux = {27'h000_0000, flags_q};
        end else if (sel_maddr) begin
            rd_mux = {24'h00_0000, mem_addr_q};
        end else if (sel_mdata) begin
            rd_mux = {24'h00_0000, mem_q[mem_addr_q]};
        end else begin
            rd_mux = status_word;
        end
    end

    assign prdata_d = (pready_d && !PWRITE) ? rd_mux : 32'h0000_0000;

    // command fields
    assign cmd_op   = aad_pkg::aad_op_t'(cmd_q[`AAD_CMD_OP_MSB:`AAD_CMD_OP_LSB]);
    assign cmd_addr = cmd_q[`AAD_CMD_ADDR_MSB:`AAD_CMD_ADDR_LSB];
    assign cmd_imm  = cmd_q[`AAD_CMD_IMM_MSB:`AAD_CMD_IMM_LSB];
    // launch only when byte 0 (the opcode) is written
    assign start    = commit_wr && sel_cmd && PSTRB[0];
    assign exec_now = (state_q == aad_pkg::ST_EXEC);

    aad_alu u_alu (
        .op      (cmd_op),
        .acc     (acc_q),
        .opnd    (opnd_q),
        .imm     (cmd_imm),
        .alu_out (alu_out)
    );

    assign alu_flag_bits = alu_out.flags;

    // operand is latched a cycle ahead so the memory read stays off the alu path
    always_comb begin
        state_d = state_q;
        opnd_d  = opnd_q;
        case (state_q)
            aad_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = aad_pkg::ST_LOAD;
                end
            end
            aad_pkg::ST_LOAD: begin
                opnd_d  = mem_q[cmd_addr];
                state_d = aad_pkg::ST_EXEC;
            end
            aad_pkg::ST_EXEC: begin
                state_d = aad_pkg::ST_IDLE;
            end
            default: begin
                state_d = aad_pkg::ST_IDLE;
            end
        endcase
    end

    assign busy_d = (state_d != aad_pkg::ST_IDLE);

    // register next values
    assign acc_merged   = merge_strb({24'h00_0000, acc_q}, PWDATA, PSTRB);
    assign flags_merged = merge_strb({27'h000_0000, flags_q}, PWDATA, PSTRB);
    assign mdata_merged = merge_strb({24'h00_0000, mem_q[mem_addr_q]}, PWDATA, PSTRB);

    assign cmd_d = (commit_wr && sel_cmd) ? merge_strb(cmd_q, PWDATA, PSTRB) : cmd_q;

    // a function result cannot be sliced directly, so it goes through a named wire
    assign maddr_merged = merge_strb({24'h00_0000, mem_addr_q}, PWDATA, PSTRB);
    assign mem_addr_d   = (commit_wr && sel_maddr) ? maddr_merged[7:0] : mem_addr_q;

    assign acc_d = (exec_now && alu_out.wr_acc) ? alu_out.result :
                   (commit_wr && sel_acc)       ? acc_merged[7:0] :
                   acc_q;

    // only the flags in the alu mask move; the rest hold their value
    assign flags_d = exec_now
                     ? ((flags_q & ~alu_out.flag_mask)
                        | (alu_flag_bits & alu_out.flag_mask))
                     : ((commit_wr && sel_flags) ? flags_merged[4:0] : flags_q);

    // done is write-one-to-clear; completion in the same cycle wins
    assign done_clr = commit_wr && sel_status && PSTRB[0] && PWDATA[`AAD_STS_DONE_BIT];
    assign done_d   = exec_now ? 1'b1 : (done_clr ? 1'b0 : done_q);
    assign cnt_d    = exec_now ? cnt_q + 16'h0001 : cnt_q;

    assign exec_mem_we = exec_now && alu_out.wr_mem;
    assign apb_mem_we  = commit_wr && sel_mdata;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            acc_q      <= `AAD_RST_ACC;
            flags_q    <= `AAD_RST_FLAGS;
            cmd_q      <= `AAD_RST_CMD;
            mem_addr_q <= `AAD_RST_MEM_ADDR;
            done_q     <= 1'b0;
            cnt_q      <= `AAD_RST_CNT;
            opnd_q     <= 8'h00;
            state_q    <= aad_pkg::ST_IDLE;
            busy_q     <= 1'b0;
        end else begin
            acc_q      <= acc_d;
            flags_q    <= flags_d;
            cmd_q      <= cmd_d;
            mem_addr_q <= mem_addr_d;
            done_q     <= done_d;
            cnt_q      <= cnt_d;
            opnd_q     <= opnd_d;
            state_q    <= state_d;
            busy_q     <= busy_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // data memory has no reset; apb writes are refused while busy, so no port clash
    always_ff @(posedge CLK_SYS) begin
        if (exec_mem_we) begin
            mem_q[cmd_addr] <= alu_out.result;
        end else if (apb_mem_we) begin
            mem_q[mem_addr_q] <= mdata_merged[7:0];
        end
    end

    assign PRDATA    = prdata_q;
    assign PREADY    = pready_q;
    assign PSLVERR   = pslverr_q;
    assign ACC_VALUE = acc_q;
    assign FLAGS     = flags_q;
    assign BUSY      = busy_q;

endmodule // aad_datapath

// [dv/aad_datapath_chk.sv]
// port assertions for the add/and datapath
`timescale 1ns/1ps
module aad_chk (
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // core state
    input wire logic [7:0]  ACC_VALUE,
    input wire logic [4:0]  FLAGS,
    input wire logic        BUSY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [1:0] op_q;
    logic [7:0] imm_q;
    wire        go = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR
                     && PADDR == 12'h000 && PSTRB[0];
    // op and immediate kept from the launching write, stable for the whole run
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            op_q  <= 2'h0;
            imm_q <= 8'h00;
        end else if (go) begin
            op_q  <= PWDATA[1:0];
            // the immediate lane only moves when its strobe is set
            imm_q <= PSTRB[2] ? PWDATA[23:16] : imm_q;
        end
    end
    a_pready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_one_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
        else $error("ready not after one wait");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_busy_run: assert property (go |=> BUSY [*2] ##1 !BUSY)
        else $error("run length wrong");
    a_and_flags: assert property ($fell(BUSY) && op_q != 2'h0 |->
        (FLAGS & 5'h1B) == ($past(FLAGS) & 5'h1B))
        else $error("logic op touched other flags");
    a_and_zero: assert property ($fell(BUSY) && (op_q[0] ^ op_q[1]) |->
        FLAGS[2] == (ACC_VALUE == 8'h00))
        else $error("zero flag wrong");
    a_imm_result: assert property ($fell(BUSY) && op_q == 2'h2 |->
        ACC_VALUE == ($past(ACC_VALUE) & imm_q))
        else $error("immediate result wrong");
    a_acc_kept: assert property ($fell(BUSY) && op_q[0] == op_q[1] |->
        $stable(ACC_VALUE))
        else $error("memory op changed acc");
endmodule // aad_chk

bind aad_datapath aad_chk aad_chk_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ACC_VALUE(ACC_VALUE), .FLAGS(FLAGS), .BUSY(BUSY)
);

// [dv/aad_apb_host.sv]
// apb master model on the register side of the datapath
`timescale 1ns/1ps
module aad_apb_host (
    // clock
    input wire logic    clk,
    // request
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0]  pstrb,
    // answer
    input wire logic    pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // k keeps psel up so a setup may follow at once; otherwise one idle cycle
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic k, output logic to);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        to = (pready !== 1'b1);
        penable <= 1'b0;
        if (!k) begin
            psel <= 1'b0;
            @(posedge clk);
        end
    endtask
endmodule // aad_apb_host

// [dv/aad_datapath_tb.sv]
// self-checking bench for the add/and datapath
`timescale 1ns/1ps
module aad_datapath_tb;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [7:0]  acc_value;
    logic [4:0]  flags;
    logic [32:0] exp_q[$];
    int          fail_count;
    int          total_checks;
    integer      seed = 32'hBC68;

    aad_datapath aad_datapath_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ACC_VALUE(acc_value), .FLAGS(flags), .BUSY(busy)
    );
    aad_apb_host aad_apb_host_i (
        .clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready)
    );

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [32:0] e, input logic k);
        logic to;
        exp_q.push_back(e);
        aad_apb_host_i.xfer(w, a, d, s, k, to);
        if (to) begin
            fail_count++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0,
                      input logic [3:0] s = 4'hF, input logic k = 1'b0);
        bus(1'b1, a, d, s, {e, 32'h0000_0000}, k);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic e = 1'b0);
        bus(1'b0, a, 32'h0000_0000, 4'h0, {e, v}, 1'b0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // every answer is matched against the oldest note
    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("mismatch apb expected none seen %h", {pslverr, prdata});
            end else begin
                check("apb", {pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        logic [7:0] a, m, x, ad, r, ea, em, l;
        logic [8:0] s9;
        logic [4:0] f, ef, h;
        logic [1:0] op;
        int n;
        fail_count = 0;
        total_checks = 0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(12'h008, 32'h0000_0000);
        rd(12'h014, 32'h0000_0000);
        rd(12'h018, 32'h0000_0000, 1'b1);
        wr(12'h018, 32'hFFFF_FFFF, 1'b1);
        for (int i = 0; i < 12; i++) begin
            op = 2'(i);
            a = 8'($random(seed));
            m = 8'($random(seed));
            x = 8'($random(seed));
            ad = 8'($random(seed));
            f = 5'($random(seed));
            wr(12'h00C, {24'h000000, ad});
            wr(12'h010, {24'h000000, m});
            wr(12'h004, {24'h000000, a});
            wr(12'h008, {27'h0000000, f});
            wr(12'h000, {8'h00, x, ad, 6'h00, op}, 1'b0, 4'hF, i == 5);
            // back-to-back write lands while the run is busy and must be refused
            if (i == 5) begin
                wr(12'h004, 32'h0000_00FF, 1'b1);
            end
            for (n = 0; n < 20 && busy !== 1'b0; n++) begin
                @(posedge clk_sys);
            end
            if (n == 20) begin
                fail_count++;
                wrap_up();
            end
            s9 = {1'b0, a} + {1'b0, m};
            h = {1'b0, a[3:0]} + {1'b0, m[3:0]};
            l = {1'b0, a[6:0]} + {1'b0, m[6:0]};
            r = (op == 2'h2) ? (a & x) : (op == 2'h0) ? s9[7:0] : (a & m);
            ea = (op[0] ^ op[1]) ? r : a;
            em = (op[0] ^ op[1]) ? m : r;
            ef = f;
            ef[2] = (r == 8'h00);
            if (op == 2'h0) begin
                ef = {l[7] ^ s9[8] ^ r[7], l[7] ^ s9[8], r == 8'h00, h[4], s9[8]};
            end
            check("acc_port", acc_value, {25'h0000000, ea});
            check("flags_port", flags, {28'h0000000, ef});
            rd(12'h004, {24'h000000, ea});
            rd(12'h008, {27'h0000000, ef});
            rd(12'h010, {24'h000000, em});
        end
        rd(12'h014, 32'h000C_0002);
        wr(12'h014, 32'h0000_0002);
        wr(12'h000, 32'h0000_0001, 1'b0, 4'hE);
        check("busy", busy, 33'h0_0000_0000);
        rd(12'h014, 32'h000C_0000);
        wrap_up();
    end
endmodule // aad_datapath_tb
